// File: core/iwd_pkg.sv
/*
  Constants, register map, field layout and types of the independent
  watchdog timer. Assumes a single 100 MHz system clock domain.
*/
`default_nettype none
package iwd_pkg;
  // ----------------------------------------------------------------
  // Counter and bus
  // ----------------------------------------------------------------
  localparam int CNT_W = 14;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_REFRESH = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RSTCTL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_CSTP = 8'h10;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_TOPS_LSB = 0;
  localparam int CTRL_CKS_LSB = 4;
  localparam int CTRL_RPES_LSB = 8;
  localparam int CTRL_RPSS_LSB = 12;
  localparam int STAT_UNF_BIT = 14;
  localparam int STAT_REF_BIT = 15;
  localparam int RSTCTL_SEL_BIT = 7;
  localparam int CSTP_BIT = 7;
  localparam int OPT_AUTO_BIT = 1;
  localparam int OPT_TOPS_LSB = 2;
  localparam int OPT_CKS_LSB = 4;
  localparam int OPT_RPES_LSB = 8;
  localparam int OPT_RPSS_LSB = 10;
  localparam int OPT_SEL_BIT = 12;
  localparam int OPT_LPS_BIT = 14;
  // ----------------------------------------------------------------
  // Reset values and refresh codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_RST = 16'h33f3;
  localparam logic [7:0] RSTCTL_RST = 8'h00;
  localparam logic [7:0] CSTP_RST = 8'h00;
  localparam logic [7:0] REF_FIRST = 8'h00;
  localparam logic [7:0] REF_SECOND = 8'hff;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] psc;
    logic [1:0] tops;
    logic [1:0] wstart;
    logic [1:0] wend;
    logic irq_sel;
    logic lp_stop;
  } iwd_cfg_t;
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_STOP = 2'b01,
    ST_RUN = 2'b11
  } iwd_state_t;
  // Last prescaler count for each divide code
  function automatic logic [7:0] div_last(input logic [3:0] code);
    case (code)
      4'h2: div_last = 8'h0f;
      4'h3: div_last = 8'h1f;
      4'h4: div_last = 8'h3f;
      4'h5: div_last = 8'hff;
      4'hf: div_last = 8'h7f;
      default: div_last = 8'h00;
    endcase
  endfunction
  // Reload value for each timeout code
  function automatic logic [CNT_W-1:0] top_val(input logic [1:0] sel);
    case (sel)
      2'h0: top_val = 14'h03ff;
      2'h1: top_val = 14'h0fff;
      2'h2: top_val = 14'h1fff;
      default: top_val = 14'h3fff;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: core/iwd_top.sv
/*
  Independent watchdog timer with an AHB-Lite register slave.
  Assumes: wdt_clk_pin and lowpower_pin are asynchronous to clk;
  option_word is a static strap taken at the first edge after reset.
*/
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1: Dedicated clock feeds a prescaler of 1, 16, 32, 64, 128 or 256.
// RQ2: Fourteen-bit down-counter decrements once per prescaled tick while running.
// RQ3: Auto-start mode begins counting right after reset release.
// RQ4: Register start mode begins counting on a 00h then FFh refresh.
// RQ5: Reset stops counting and restores counter and registers.
// RQ6: Counting halts in low power when enabled by a register.
// RQ7: Register start mode stops after underflow or refresh error.
// RQ8: Programmable window start and end split each period.
// RQ9: Refresh outside the window is an error reported like underflow.
// RQ10: A bit selects reset output or interrupt output.
// RQ11: Interrupt output may serve as non-maskable or ordinary interrupt.
// RQ12: Status register shows the current counter value.
// RQ13: Event outputs pulse on underflow and on refresh error.
// RQ14: A sleep count-stop control output is provided.
// RQ15: Auto-start takes all settings from the option word.
// RQ16: Register start takes divider, timeout and window from control.
// RQ17: Count-stop bit halts decrement in all low power states.
// RQ18: Software uses only the listed divide codes.
// RQ19: Refresh error flag stays set until software clears it.
// RQ20: Only FFh directly after 00h counts as a refresh.
// RQ21: Refresh reloads the timeout count; underflow past zero.
module iwd_top #(
  parameter int CNT_W = iwd_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic wdt_clk_pin,
  input wire logic lowpower_pin,
  input wire logic [15:0] option_word,
  output logic wdt_reset_req,
  output logic wdt_irq_req,
  output logic evt_underflow,
  output logic evt_refresh_error,
  output logic count_stop_ctrl
);
  localparam int CW = CNT_W;

  // Reload and window tables only serve the package width
  if (CNT_W != iwd_pkg::CNT_W)
  begin : g_width_check
    $error("Counter width does not match the reload table width");
  end
  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic wr_q, wr_d;
  logic [iwd_pkg::ADDR_W-1:0] wa_q, wa_d;
  logic [31:0] rd_q, rd_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic [7:0] rstctl_q, rstctl_d;
  logic [7:0] cstp_q, cstp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic unf_flag_q, unf_flag_d;
  logic ref_flag_q, ref_flag_d;
  logic addr_ok;
  logic [iwd_pkg::ADDR_W-1:0] ra;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_q;
  assign ra = haddr[iwd_pkg::ADDR_W-1:0];

  always_comb
  begin
    addr_ok = hsel && hready && htrans[1];
    wr_d = addr_ok && hwrite;
    wa_d = addr_ok ? ra : wa_q;
    rd_d = 32'h0000_0000;
    if (addr_ok && !hwrite)
    begin
      case (ra)
        iwd_pkg::OFF_CTRL: rd_d = {16'h0000, ctrl_q};
        iwd_pkg::OFF_STAT: rd_d = {16'h0000, ref_flag_q, unf_flag_q, cnt_q}; // RQ12
        iwd_pkg::OFF_RSTCTL: rd_d = {24'h00_0000, rstctl_q};
        iwd_pkg::OFF_CSTP: rd_d = {24'h00_0000, cstp_q};
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= 1'b0;
      wa_q <= '0;
      rd_q <= 32'h0000_0000;
    end
    else
    begin
      wr_q <= wr_d;
      wa_q <= wa_d;
      rd_q <= rd_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic wc1_q, wc2_q, wc3_q, lp1_q, lp2_q;
  logic src_tick;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wc1_q <= 1'b0;
      wc2_q <= 1'b0;
      wc3_q <= 1'b0;
      lp1_q <= 1'b0;
      lp2_q <= 1'b0;
    end
    else
    begin
      wc1_q <= wdt_clk_pin;
      wc2_q <= wc1_q;
      wc3_q <= wc2_q;
      lp1_q <= lowpower_pin;
      lp2_q <= lp1_q;
    end
  end

  assign src_tick = wc2_q && !wc3_q; // RQ1

  // ----------------------------------------------------------------
  // Watchdog core
  // ----------------------------------------------------------------
  iwd_pkg::iwd_state_t st_q, st_d;
  logic auto_q, auto_d;
  iwd_pkg::iwd_cfg_t opt_q, opt_d, reg_cfg, cfg;
  logic [7:0] psc_q, psc_d;
  logic arm_q, arm_d;
  logic unf_ev_q, unf_ev_d, ref_ev_q, ref_ev_d;
  logic rst_req_q, rst_req_d, irq_q, irq_d;
  logic halt, ptick, refresh, in_win, unf, ref_err, wr_ref, wr_stat;
  logic [CW-1:0] top, start_thr, end_thr;
  logic [CW:0] period;
  logic [CW-1:0] qtr;
  logic [CW+1:0] q3;

  always_comb
  begin
    reg_cfg.psc = ctrl_q[iwd_pkg::CTRL_CKS_LSB +: 4]; // RQ16
    reg_cfg.tops = ctrl_q[iwd_pkg::CTRL_TOPS_LSB +: 2];
    reg_cfg.wstart = ctrl_q[iwd_pkg::CTRL_RPSS_LSB +: 2];
    reg_cfg.wend = ctrl_q[iwd_pkg::CTRL_RPES_LSB +: 2];
    reg_cfg.irq_sel = rstctl_q[iwd_pkg::RSTCTL_SEL_BIT];
    reg_cfg.lp_stop = cstp_q[iwd_pkg::CSTP_BIT];
  end

  assign cfg = auto_q ? opt_q : reg_cfg; // RQ15
  assign top = iwd_pkg::top_val(cfg.tops);
  assign period = {1'b0, top} + {{CW{1'b0}}, 1'b1};
  assign qtr = {1'b0, period[CW:2]};
  assign q3 = {2'b00, qtr} + {1'b0, qtr, 1'b0};

  // Window thresholds as quarters of the period
  always_comb
  begin
    case (cfg.wstart) // RQ8
      2'h0: start_thr = top;
      2'h1: start_thr = q3[CW-1:0] - 14'h0001;
      2'h2: start_thr = {qtr[CW-2:0], 1'b0} - 14'h0001;
      default: start_thr = qtr - 14'h0001;
    endcase
    case (cfg.wend)
      2'h0: end_thr = 14'h0000;
      2'h1: end_thr = qtr;
      2'h2: end_thr = {qtr[CW-2:0], 1'b0};
      default: end_thr = q3[CW-1:0];
    endcase
  end

  assign in_win = (cnt_q <= start_thr) && (cnt_q >= end_thr);
  assign halt = cfg.lp_stop && lp2_q; // RQ6 RQ17
  assign ptick = (st_q == iwd_pkg::ST_RUN) && src_tick && !halt
                 && (psc_q == iwd_pkg::div_last(cfg.psc)); // RQ1 RQ18
  assign wr_ref = wr_q && (wa_q == iwd_pkg::OFF_REFRESH);
  assign wr_stat = wr_q && (wa_q == iwd_pkg::OFF_STAT);
  assign refresh = wr_ref && arm_q && (hwdata[7:0] == iwd_pkg::REF_SECOND); // RQ20
  assign ref_err = refresh && (st_q == iwd_pkg::ST_RUN) && !in_win; // RQ9
  assign unf = ptick && (cnt_q == 14'h0000) && !refresh; // RQ21

  always_comb
  begin
    st_d = st_q;
    auto_d = auto_q;
    opt_d = opt_q;
    cnt_d = cnt_q;
    psc_d = psc_q;
    arm_d = arm_q;
    ctrl_d = ctrl_q;
    rstctl_d = rstctl_q;
    cstp_d = cstp_q;
    if (wr_ref)
    begin
      arm_d = (hwdata[7:0] == iwd_pkg::REF_FIRST); // RQ4 RQ20
    end
    if (wr_q && st_q != iwd_pkg::ST_RUN)
    begin
      if (wa_q == iwd_pkg::OFF_CTRL)
      begin
        ctrl_d = hwdata[15:0];
      end
      if (wa_q == iwd_pkg::OFF_RSTCTL)
      begin
        rstctl_d = hwdata[7:0] & 8'h80;
      end
      if (wa_q == iwd_pkg::OFF_CSTP)
      begin
        cstp_d = hwdata[7:0] & 8'h80;
      end
    end
    if (st_q == iwd_pkg::ST_RUN && src_tick && !halt)
    begin
      psc_d = ptick ? 8'h00 : psc_q + 8'h01;
    end
    if (ptick && cnt_q != 14'h0000)
    begin
      cnt_d = cnt_q - 14'h0001; // RQ2
    end
    case (st_q)
      iwd_pkg::ST_BOOT:
      begin
        auto_d = option_word[iwd_pkg::OPT_AUTO_BIT];
        opt_d.psc = option_word[iwd_pkg::OPT_CKS_LSB +: 4];
        opt_d.tops = option_word[iwd_pkg::OPT_TOPS_LSB +: 2];
        opt_d.wstart = option_word[iwd_pkg::OPT_RPSS_LSB +: 2];
        opt_d.wend = option_word[iwd_pkg::OPT_RPES_LSB +: 2];
        opt_d.irq_sel = option_word[iwd_pkg::OPT_SEL_BIT];
        opt_d.lp_stop = option_word[iwd_pkg::OPT_LPS_BIT];
        cnt_d = option_word[iwd_pkg::OPT_AUTO_BIT]
                ? iwd_pkg::top_val(option_word[iwd_pkg::OPT_TOPS_LSB +: 2])
                : iwd_pkg::top_val(iwd_pkg::CTRL_RST[iwd_pkg::CTRL_TOPS_LSB +: 2]);
        psc_d = 8'h00;
        st_d = option_word[iwd_pkg::OPT_AUTO_BIT]
               ? iwd_pkg::ST_RUN : iwd_pkg::ST_STOP; // RQ3
      end
      iwd_pkg::ST_STOP:
      begin
        if (refresh)
        begin
          cnt_d = top; // RQ4 RQ21
          psc_d = 8'h00;
          st_d = iwd_pkg::ST_RUN;
        end
      end
      iwd_pkg::ST_RUN:
      begin
        if (refresh || unf)
        begin
          cnt_d = top; // RQ21
          psc_d = 8'h00;
        end
        if ((ref_err || unf) && !auto_q)
        begin
          st_d = iwd_pkg::ST_STOP; // RQ7
        end
      end
      default: st_d = iwd_pkg::ST_BOOT;
    endcase
    // Hardware set wins over software clear
    unf_flag_d = unf || (unf_flag_q && !(wr_stat && !hwdata[iwd_pkg::STAT_UNF_BIT]));
    ref_flag_d = ref_err
                 || (ref_flag_q && !(wr_stat && !hwdata[iwd_pkg::STAT_REF_BIT])); // RQ19
    unf_ev_d = unf; // RQ13
    ref_ev_d = ref_err;
    rst_req_d = (unf || ref_err) && !cfg.irq_sel; // RQ10
    irq_d = (unf || ref_err) && cfg.irq_sel; // RQ11
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= iwd_pkg::ST_BOOT; // RQ5
      auto_q <= 1'b0;
      opt_q <= '0;
      cnt_q <= '0;
      psc_q <= 8'h00;
      arm_q <= 1'b0;
      ctrl_q <= iwd_pkg::CTRL_RST;
      rstctl_q <= iwd_pkg::RSTCTL_RST;
      cstp_q <= iwd_pkg::CSTP_RST;
      unf_flag_q <= 1'b0;
      ref_flag_q <= 1'b0;
      unf_ev_q <= 1'b0;
      ref_ev_q <= 1'b0;
      rst_req_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      auto_q <= auto_d;
      opt_q <= opt_d;
      cnt_q <= cnt_d;
      psc_q <= psc_d;
      arm_q <= arm_d;
      ctrl_q <= ctrl_d;
      rstctl_q <= rstctl_d;
      cstp_q <= cstp_d;
      unf_flag_q <= unf_flag_d;
      ref_flag_q <= ref_flag_d;
      unf_ev_q <= unf_ev_d;
      ref_ev_q <= ref_ev_d;
      rst_req_q <= rst_req_d;
      irq_q <= irq_d;
    end
  end

  assign evt_underflow = unf_ev_q;
  assign evt_refresh_error = ref_ev_q;
  assign wdt_reset_req = rst_req_q;
  assign wdt_irq_req = irq_q;
  assign count_stop_ctrl = halt; // RQ14

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence seq_good_refresh;
    refresh && (st_q == iwd_pkg::ST_RUN) && in_win;
  endsequence
  sequence seq_bad_refresh;
    refresh && (st_q == iwd_pkg::ST_RUN) && !in_win;
  endsequence

  chk_refresh_reload: assert property (seq_good_refresh |=> cnt_q == $past(top)) // RQ21
    else $error("Refresh in window did not reload counter");
  chk_refresh_error: assert property (seq_bad_refresh |=> evt_refresh_error ##1 !evt_refresh_error) // RQ9
    else $error("Refresh outside window did not give one error pulse");
  chk_underflow_evt: assert property (ptick && cnt_q == 14'h0000 && !refresh
                                       |=> evt_underflow && cnt_q == $past(top)) // RQ13
    else $error("Underflow did not pulse event and reload");
  chk_reg_stop: assert property ((unf || ref_err) && !auto_q
                                 |=> st_q == iwd_pkg::ST_STOP) // RQ7
    else $error("Register start mode kept counting after fault");
  chk_count_step: assert property (ptick && cnt_q != 14'h0000 && !refresh
                                   |=> cnt_q == $past(cnt_q) - 14'h0001) // RQ2
    else $error("Counter did not decrement by one");
  chk_halt_hold: assert property (st_q == iwd_pkg::ST_RUN && halt && !refresh
                                  |=> $stable(cnt_q)) // RQ6
    else $error("Counter moved while halted");
  chk_route_select: assert property ($rose(evt_underflow) || $rose(evt_refresh_error)
                                     |-> wdt_reset_req != wdt_irq_req) // RQ10
    else $error("Fault not routed to exactly one output");
  chk_flag_sticky: assert property (ref_flag_q && !wr_stat |=> ref_flag_q) // RQ19
    else $error("Refresh error flag lost");
  chk_auto_start: assert property (st_q == iwd_pkg::ST_BOOT
                                   && option_word[iwd_pkg::OPT_AUTO_BIT]
                                   |=> st_q == iwd_pkg::ST_RUN) // RQ3
    else $error("Auto-start did not run after reset");
  chk_stop_start: assert property (st_q == iwd_pkg::ST_STOP && !refresh
                                   |=> st_q == iwd_pkg::ST_STOP) // RQ4
    else $error("Counter started without refresh");
endmodule
`default_nettype wire

// File: tb/iwd_top_bench.sv
/*
  Self-checking bench for the independent watchdog timer top.
  Assumes the register map, encodings and timing of the iwd_pkg package.
*/
`timescale 1ns/1ps
`default_nettype none
module iwd_top_bench;
  logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, a;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic wdt_clk_pin, lowpower_pin;
  logic [15:0] option_word;
  logic wdt_reset_req, wdt_irq_req, evt_underflow, evt_refresh_error, count_stop_ctrl;
  int fails, cmp_count, n_uf, n_re, n_rst, n_irq;

  assign hready = hreadyout;

  iwd_top dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wdt_clk_pin(wdt_clk_pin),
    .lowpower_pin(lowpower_pin), .option_word(option_word), .wdt_reset_req(wdt_reset_req),
    .wdt_irq_req(wdt_irq_req), .evt_underflow(evt_underflow),
    .evt_refresh_error(evt_refresh_error), .count_stop_ctrl(count_stop_ctrl));

  // ----------------------------------------------------------------
  // Clocks and pulse counters
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    wdt_clk_pin = 1'b0;
    forever #40 wdt_clk_pin = ~wdt_clk_pin;
  end

  always @(posedge clk)
  begin
    if (evt_underflow === 1'b1) n_uf++;
    if (evt_refresh_error === 1'b1) n_re++;
    if (wdt_reset_req === 1'b1) n_rst++;
    if (wdt_irq_req === 1'b1) n_irq++;
  end

  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, addr};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= data;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic bus_wr(input logic [7:0] addr, input logic [31:0] data);
    bus_xfer(1'b1, addr, data);
  endtask

  task automatic bus_rd(input logic [7:0] addr);
    bus_xfer(1'b0, addr, 32'h0000_0000);
  endtask

  task automatic refresh();
    bus_wr(iwd_pkg::OFF_REFRESH, {24'h00_0000, iwd_pkg::REF_FIRST});
    bus_wr(iwd_pkg::OFF_REFRESH, {24'h00_0000, iwd_pkg::REF_SECOND});
  endtask

  task automatic complete_run();
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    lowpower_pin = 1'b0;
    option_word = 16'h0000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    // Reset values and unmapped space
    bus_rd(iwd_pkg::OFF_CTRL);
    check("ctrl reset", {16'h0000, iwd_pkg::CTRL_RST}, rd);
    bus_rd(iwd_pkg::OFF_RSTCTL);
    check("rstctl reset", 32'h0000_0000, rd);
    bus_rd(iwd_pkg::OFF_CSTP);
    check("cstp reset", 32'h0000_0000, rd);
    bus_rd(8'h14);
    check("unmapped read", 32'h0000_0000, rd);
    check("hresp", 32'h0000_0000, {31'h0, hresp});
    check("hreadyout", 32'h0000_0001, {31'h0, hreadyout});
    // Broken sequence must not start the counter
    bus_wr(iwd_pkg::OFF_CTRL, 32'h0000_0000);
    bus_wr(iwd_pkg::OFF_REFRESH, 32'h0000_0000);
    bus_wr(iwd_pkg::OFF_REFRESH, 32'h0000_0012);
    bus_wr(iwd_pkg::OFF_REFRESH, 32'h0000_00ff);
    bus_rd(iwd_pkg::OFF_STAT);
    a = rd;
    repeat (400) @(posedge clk);
    bus_rd(iwd_pkg::OFF_STAT);
    check("stopped count", {18'h0, a[13:0]}, {18'h0, rd[13:0]});
    // Valid refresh starts and reloads
    refresh();
    bus_rd(iwd_pkg::OFF_STAT);
    check("count after start", 32'h1, {31'h0, rd[13:0] <= 14'h03ff && rd[13:0] >= 14'h03f0});
    bus_wr(iwd_pkg::OFF_CTRL, 32'h0000_33f3);
    bus_rd(iwd_pkg::OFF_CTRL);
    check("ctrl locked", 32'h0000_0000, rd);
    for (int i = 0; i < 20000 && n_uf == 0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    check("underflow events", 32'h1, n_uf);
    check("reset pulses", 32'h1, n_rst);
    check("irq pulses", 32'h0, n_irq);
    bus_rd(iwd_pkg::OFF_STAT);
    check("status after underflow", 32'h0000_43ff, rd);
    repeat (400) @(posedge clk);
    bus_rd(iwd_pkg::OFF_STAT);
    check("stop after underflow", 32'h0000_43ff, rd);
    // Refresh outside the window, interrupt selected
    bus_wr(iwd_pkg::OFF_STAT, 32'h0000_0000);
    bus_wr(iwd_pkg::OFF_RSTCTL, 32'h0000_0080);
    bus_wr(iwd_pkg::OFF_CTRL, 32'h0000_3000);
    refresh();
    refresh();
    repeat (4) @(posedge clk);
    check("error events", 32'h1, n_re);
    check("irq on error", 32'h1, n_irq);
    check("no reset on error", 32'h1, n_rst);
    repeat (200) @(posedge clk);
    bus_rd(iwd_pkg::OFF_STAT);
    check("status after error", 32'h0000_83ff, rd);
    bus_wr(iwd_pkg::OFF_STAT, 32'h0000_4000);
    bus_rd(iwd_pkg::OFF_STAT);
    check("flag cleared", 32'h0000_03ff, rd);
    // Low power halt
    bus_wr(iwd_pkg::OFF_CTRL, 32'h0000_0000);
    bus_wr(iwd_pkg::OFF_CSTP, 32'h0000_0080);
    refresh();
    lowpower_pin <= 1'b1;
    repeat (10) @(posedge clk);
    check("stop control", 32'h1, {31'h0, count_stop_ctrl});
    bus_rd(iwd_pkg::OFF_STAT);
    a = rd;
    repeat (400) @(posedge clk);
    bus_rd(iwd_pkg::OFF_STAT);
    check("frozen in low power", a, rd);
    lowpower_pin <= 1'b0;
    repeat (400) @(posedge clk);
    bus_rd(iwd_pkg::OFF_STAT);
    check("resumes", 32'h1, {31'h0, rd[13:0] < a[13:0]});
    // Reset mid-run, then auto-start at divide by 16
    rst_n <= 1'b0;
    option_word <= 16'h0022;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus_rd(iwd_pkg::OFF_CSTP);
    check("cstp after reset", 32'h0000_0000, rd);
    bus_rd(iwd_pkg::OFF_STAT);
    a = rd;
    check("flags after reset", 32'h0, {30'h0, a[15:14]});
    repeat (1280) @(posedge clk);
    bus_rd(iwd_pkg::OFF_STAT);
    a = a - rd;
    check("auto count /16", 32'h1, {31'h0, a[13:0] >= 14'h0008 && a[13:0] <= 14'h000c});
    // Auto-start at divide by 1: late refresh, interrupt route, option stop
    rst_n <= 1'b0;
    option_word <= 16'h5302;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2200) @(posedge clk);
    refresh();
    repeat (4) @(posedge clk);
    check("late refresh events", 32'h0000_0002, n_re);
    check("late refresh irq", 32'h0000_0002, n_irq);
    check("late refresh reset", 32'h0000_0001, n_rst);
    bus_rd(iwd_pkg::OFF_STAT);
    a = rd;
    check("auto error flags", 32'h0000_0002, {30'h0, a[15:14]});
    check("auto reload", 32'h1, {31'h0, a[13:0] >= 14'h03f0});
    refresh();
    repeat (4) @(posedge clk);
    check("refresh in window", 32'h0000_0002, n_re);
    repeat (400) @(posedge clk);
    bus_rd(iwd_pkg::OFF_STAT);
    check("auto keeps running", 32'h1, {31'h0, rd[13:0] < 14'h03f0});
    lowpower_pin <= 1'b1;
    repeat (10) @(posedge clk);
    check("option stop control", 32'h1, {31'h0, count_stop_ctrl});
    complete_run();
  end
endmodule
`default_nettype wire
